// ===== rtl/fewc_pkg.sv
// What this block does
// - external data write to flash range starts write
// - flash write ignored unless flash unlock set
// - cpu waits about 1 ms per flash byte
// - peripherals run on during stall; software services interrupts
// - flash reads by data or code, no wait
// - 65h sets whole area flag, else clears
// - protection register bit 0 reads whole area flag
// - main area writable only with whole area flag
// - 47h flash unlock, e2h eeprom unlock, else clear
// - unlock bit 7 shows flash unlock
// - unlock bit 5 shows eeprom unlock
// - bit 6 time-out flag, cleared with unlock
// - time-out select off, 1, 3.9, 7.8 ms
// - one time-out serves flash and eeprom
// - watchdog field 0x off, 10 run, 11 always
// - eeprom 128 bytes even addresses ee00h-eefeh
// - eeprom write stalls cpu about 2 ms
// - eeprom read takes about 300 ns
// - software clears unlock flags after each write
// - software disables watchdog before writing
package fewc_pkg;
  // ==========================================================
  // register offsets and fields
  localparam logic [7:0] REG_PROTECT = 8'h97;
  localparam logic [7:0] REG_UNLOCK = 8'hc9;
  localparam logic [7:0] REG_AUX_CONTROL_TWO = 8'hf7;
  localparam logic [7:0] CMD_WHOLE = 8'h65;
  localparam logic [7:0] CMD_FLASH = 8'h47;
  localparam logic [7:0] CMD_EEPROM = 8'he2;
  localparam logic [7:0] AUX_CONTROL_TWO_RESET = 8'h06;
  localparam int BIT_FLASH_UNLOCK = 7;
  localparam int BIT_TIMEOUT = 6;
  localparam int BIT_EE_UNLOCK = 5;
  localparam int BIT_TSEL_LO = 1;
  localparam int BIT_WDT_LO = 6;
  // ==========================================================
  // address map
  localparam logic [15:0] FLASH_LAST = 16'h3ffe;
  localparam logic [15:0] MAIN_LAST = 16'h3eff;
  localparam logic [15:0] CFG_OPEN_FIRST = 16'h3ff0;
  localparam logic [15:0] CFG_OPEN_LAST = 16'h3ff7;
  localparam logic [15:0] EE_FIRST = 16'hee00;
  localparam logic [15:0] EE_LAST = 16'heefe;
  localparam int EE_BYTES = 128;
  // ==========================================================
  // timing, 200 MHz clock
  localparam int CLK_MHZ = 200;
  localparam int FLASH_WRITE_US = 1000;
  localparam int EE_WRITE_US = 2000;
  localparam int TO1_US = 1000;
  localparam int TO2_US = 3900;
  localparam int TO3_US = 7800;
  localparam int EE_READ_NS = 300;
  localparam int FLASH_WRITE_CYC = FLASH_WRITE_US * CLK_MHZ;
  localparam int EE_WRITE_CYC = EE_WRITE_US * CLK_MHZ;
  localparam int TO1_CYC = TO1_US * CLK_MHZ;
  localparam int TO2_CYC = TO2_US * CLK_MHZ;
  localparam int TO3_CYC = TO3_US * CLK_MHZ;
  localparam int EE_READ_CYC = (EE_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 24;
  // ==========================================================
  typedef enum logic [1:0] {
    FEWC_IDLE = 2'b00,
    FEWC_WRITE = 2'b01,
    FEWC_READ = 2'b10
  } fewc_state_t;
  typedef enum logic [1:0] {
    FEWC_WDT_OFF = 2'b00,
    FEWC_WDT_OFF1 = 2'b01,
    FEWC_WDT_RUN = 2'b10,
    FEWC_WDT_ALWAYS = 2'b11
  } fewc_wdt_t;
endpackage : fewc_pkg

// ===== rtl/fewc_if.sv
interface fewc_if;
  // cpu side requests; x_req held until done, sfr_wr and code_rd last one cycle
  logic sfr_wr;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic x_req;
  logic x_we;
  logic code_rd;
  logic [15:0] data_pointer;
  logic [7:0] acc;
  logic [7:0] x_rdata;
  logic x_done;
  logic cpu_wait;
  modport device (
    input sfr_wr, sfr_addr, sfr_wdata, x_req, x_we, code_rd, data_pointer, acc,
    output sfr_rdata, x_rdata, x_done, cpu_wait
  );
  modport cpu (
    output sfr_wr, sfr_addr, sfr_wdata, x_req, x_we, code_rd, data_pointer, acc,
    input sfr_rdata, x_rdata, x_done, cpu_wait
  );
endinterface : fewc_if

// ===== rtl/fewc_device.sv
module fewc_device #(
  parameter int FLASH_WRITE_CYC = fewc_pkg::FLASH_WRITE_CYC,
  parameter int EE_WRITE_CYC = fewc_pkg::EE_WRITE_CYC,
  parameter int TO1_CYC = fewc_pkg::TO1_CYC,
  parameter int TO2_CYC = fewc_pkg::TO2_CYC,
  parameter int TO3_CYC = fewc_pkg::TO3_CYC,
  parameter int FLASH_WORDS = 16384
) (
  input wire logic clk,
  input wire logic nrst,
  fewc_if.device bus,
  output logic [1:0] watchdog_reset_mode,
  output logic wdt_run_enable,
  output logic wdt_idle_enable,
  input wire logic write_fail
);
  localparam logic [fewc_pkg::CNT_W-1:0] FW = fewc_pkg::CNT_W'(FLASH_WRITE_CYC);
  localparam logic [fewc_pkg::CNT_W-1:0] EW = fewc_pkg::CNT_W'(EE_WRITE_CYC);
  localparam logic [fewc_pkg::CNT_W-1:0] RW = fewc_pkg::CNT_W'(fewc_pkg::EE_READ_CYC);
  localparam logic [fewc_pkg::CNT_W-1:0] ONE = fewc_pkg::CNT_W'(1);

  logic [7:0] flash_mem [FLASH_WORDS];
  logic [7:0] ee_mem [fewc_pkg::EE_BYTES];
  logic whole_area_access_flag_r;
  logic flash_write_unlock_r;
  logic eeprom_write_unlock_r;
  logic write_timeout_flag_r;
  logic [7:0] aux_control_two_r;
  fewc_pkg::fewc_state_t state_r;
  logic [fewc_pkg::CNT_W-1:0] busy_cnt_r;
  logic [fewc_pkg::CNT_W-1:0] to_cnt_r;
  logic is_ee_r;
  logic [7:0] sfr_rdata_r;
  logic [7:0] x_rdata_r;
  logic x_done_r;
  logic cpu_wait_r;
  logic [15:0] a;
  logic in_flash, in_ee, flash_ok, ee_ok, ee_odd, timeout_hit, unlock_wr;
  logic protect_wr, aux_wr;
  logic [1:0] tsel;
  logic [fewc_pkg::CNT_W-1:0] to_lim;

  // write strobe aimed at one register
  function automatic logic sfr_hit(input logic wr, input logic [7:0] sel,
      input logic [7:0] want);
    return wr && sel == want;
  endfunction : sfr_hit

  // ==========================================================
  // address decode
  assign a = bus.data_pointer;
  assign in_flash = a <= fewc_pkg::FLASH_LAST;
  assign in_ee = a >= fewc_pkg::EE_FIRST && a <= fewc_pkg::EE_LAST;
  assign ee_odd = a[0];
  assign flash_ok = in_flash && flash_write_unlock_r &&
    (a > fewc_pkg::MAIN_LAST ? (a <= fewc_pkg::CFG_OPEN_LAST || whole_area_access_flag_r)
                              : whole_area_access_flag_r);
  assign ee_ok = in_ee && !ee_odd && eeprom_write_unlock_r;
  assign tsel = aux_control_two_r[fewc_pkg::BIT_TSEL_LO +: 2];
  always_comb begin
    case (tsel)
      2'b01: to_lim = fewc_pkg::CNT_W'(TO1_CYC);
      2'b10: to_lim = fewc_pkg::CNT_W'(TO2_CYC);
      2'b11: to_lim = fewc_pkg::CNT_W'(TO3_CYC);
      default: to_lim = '0;
    endcase
  end
  // one timer for both kinds of write
  assign timeout_hit = state_r == fewc_pkg::FEWC_WRITE && tsel != 2'b00 &&
    to_cnt_r >= to_lim;
  assign unlock_wr = sfr_hit(bus.sfr_wr, bus.sfr_addr, fewc_pkg::REG_UNLOCK);
  assign protect_wr = sfr_hit(bus.sfr_wr, bus.sfr_addr, fewc_pkg::REG_PROTECT);
  assign aux_wr = sfr_hit(bus.sfr_wr, bus.sfr_addr, fewc_pkg::REG_AUX_CONTROL_TWO);

  // ==========================================================
  // special function registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      whole_area_access_flag_r <= 1'b0;
    end else if (protect_wr) begin
      whole_area_access_flag_r <= bus.sfr_wdata == fewc_pkg::CMD_WHOLE;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flash_write_unlock_r <= 1'b0;
      eeprom_write_unlock_r <= 1'b0;
    end else if (unlock_wr) begin
      flash_write_unlock_r <= bus.sfr_wdata == fewc_pkg::CMD_FLASH;
      eeprom_write_unlock_r <= bus.sfr_wdata == fewc_pkg::CMD_EEPROM;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_timeout_flag_r <= 1'b0;
    end else if (timeout_hit) begin
      write_timeout_flag_r <= 1'b1;
    end else if (!flash_write_unlock_r && !eeprom_write_unlock_r) begin
      write_timeout_flag_r <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aux_control_two_r <= fewc_pkg::AUX_CONTROL_TWO_RESET;
    end else if (aux_wr) begin
      aux_control_two_r <= bus.sfr_wdata;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata_r <= 8'h00;
    end else begin
      case (bus.sfr_addr)
        fewc_pkg::REG_PROTECT: sfr_rdata_r <= {7'h00, whole_area_access_flag_r};
        fewc_pkg::REG_UNLOCK: sfr_rdata_r <= {flash_write_unlock_r,
          write_timeout_flag_r, eeprom_write_unlock_r, 5'h00};
        fewc_pkg::REG_AUX_CONTROL_TWO: sfr_rdata_r <= aux_control_two_r;
        default: sfr_rdata_r <= 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_reset_mode <= 2'b00;
      wdt_run_enable <= 1'b0;
      wdt_idle_enable <= 1'b0;
    end else begin
      watchdog_reset_mode <= aux_control_two_r[fewc_pkg::BIT_WDT_LO +: 2];
      wdt_run_enable <= aux_control_two_r[fewc_pkg::BIT_WDT_LO + 1];
      wdt_idle_enable <= aux_control_two_r[fewc_pkg::BIT_WDT_LO +: 2] == fewc_pkg::FEWC_WDT_ALWAYS;
    end
  end

  // ==========================================================
  // access sequencer; stall only stops the cpu, nothing else
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= fewc_pkg::FEWC_IDLE;
      busy_cnt_r <= '0;
      to_cnt_r <= '0;
      is_ee_r <= 1'b0;
      x_done_r <= 1'b0;
      x_rdata_r <= 8'h00;
      cpu_wait_r <= 1'b0;
    end else begin
      x_done_r <= 1'b0;
      case (state_r)
        fewc_pkg::FEWC_IDLE: begin
          to_cnt_r <= '0;
          if (bus.x_req && !x_done_r && bus.x_we) begin
            is_ee_r <= in_ee;
            if (ee_ok) begin
              state_r <= fewc_pkg::FEWC_WRITE;
              busy_cnt_r <= EW;
              cpu_wait_r <= 1'b1;
            end else if (flash_ok) begin
              state_r <= fewc_pkg::FEWC_WRITE;
              busy_cnt_r <= FW;
              cpu_wait_r <= 1'b1;
            end else begin
              x_done_r <= 1'b1;
            end
          end else if (bus.x_req && !x_done_r && in_ee) begin
            state_r <= fewc_pkg::FEWC_READ;
            busy_cnt_r <= RW;
          end else if ((bus.x_req || bus.code_rd) && !x_done_r) begin
            x_rdata_r <= in_flash ? flash_mem[a[13:0]] : 8'h00;
            x_done_r <= bus.x_req;
          end
        end
        fewc_pkg::FEWC_WRITE: begin
          to_cnt_r <= to_cnt_r + ONE;
          if (timeout_hit) begin
            state_r <= fewc_pkg::FEWC_IDLE;
            x_done_r <= 1'b1;
            cpu_wait_r <= 1'b0;
          end else if (!write_fail) begin
            busy_cnt_r <= busy_cnt_r - ONE;
            if (busy_cnt_r <= ONE) begin
              state_r <= fewc_pkg::FEWC_IDLE;
              x_done_r <= 1'b1;
              cpu_wait_r <= 1'b0;
            end
          end
        end
        fewc_pkg::FEWC_READ: begin
          busy_cnt_r <= busy_cnt_r - ONE;
          if (busy_cnt_r <= ONE) begin
            x_rdata_r <= ee_mem[a[7:1]];
            state_r <= fewc_pkg::FEWC_IDLE;
            x_done_r <= 1'b1;
          end
        end
        default: begin
          state_r <= fewc_pkg::FEWC_IDLE;
          cpu_wait_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // arrays, committed at the end of a good write
  always_ff @(posedge clk) begin
    if (state_r == fewc_pkg::FEWC_WRITE && !timeout_hit && !write_fail &&
        busy_cnt_r <= ONE) begin
      if (is_ee_r) begin
        ee_mem[a[7:1]] <= bus.acc;
      end else begin
        flash_mem[a[13:0]] <= bus.acc;
      end
    end
  end

  assign bus.sfr_rdata = sfr_rdata_r;
  assign bus.x_rdata = x_rdata_r;
  assign bus.x_done = x_done_r;
  assign bus.cpu_wait = cpu_wait_r;
endmodule : fewc_device

// ===== rtl/fewc_cpu_end.sv
module fewc_cpu_end (
  input wire logic clk,
  input wire logic nrst,
  fewc_if.cpu bus,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid
);
  // cmd_kind: 00 sfr write, 01 data write, 10 data read, 11 code read
  logic busy_r;
  logic sfr_wr_r, x_req_r, x_we_r, code_rd_r;
  logic [15:0] data_pointer_r;
  logic [7:0] acc_r;
  logic [7:0] rsp_r;
  logic rsp_v_r;

  // ==========================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      sfr_wr_r <= 1'b0;
      x_req_r <= 1'b0;
      x_we_r <= 1'b0;
      code_rd_r <= 1'b0;
      data_pointer_r <= 16'h0000;
      acc_r <= 8'h00;
      rsp_r <= 8'h00;
      rsp_v_r <= 1'b0;
    end else begin
      sfr_wr_r <= 1'b0;
      code_rd_r <= 1'b0;
      rsp_v_r <= 1'b0;
      if (!busy_r && cmd_valid) begin
        data_pointer_r <= cmd_addr;
        acc_r <= cmd_data;
        case (cmd_kind)
          2'b00: sfr_wr_r <= 1'b1;
          2'b11: code_rd_r <= 1'b1;
          default: begin
            busy_r <= 1'b1;
            x_req_r <= 1'b1;
            x_we_r <= !cmd_kind[1];
          end
        endcase
      end else if (busy_r && bus.x_done) begin
        // stall ends here; pending interrupts are the core's to take
        busy_r <= 1'b0;
        x_req_r <= 1'b0;
        x_we_r <= 1'b0;
        rsp_r <= bus.x_rdata;
        rsp_v_r <= 1'b1;
      end
    end
  end

  assign bus.sfr_wr = sfr_wr_r;
  assign bus.sfr_addr = data_pointer_r[7:0];
  assign bus.sfr_wdata = acc_r;
  assign bus.x_req = x_req_r;
  assign bus.x_we = x_we_r;
  assign bus.code_rd = code_rd_r;
  assign bus.data_pointer = data_pointer_r;
  assign bus.acc = acc_r;
  assign cmd_ready = !busy_r;
  assign rsp_data = rsp_r;
  assign rsp_valid = rsp_v_r;
endmodule : fewc_cpu_end

// ===== bench/fewc_checker_assertions.sv
module fewc_checker (
  input logic clk,
  input logic nrst,
  input logic sfr_wr,
  input logic [7:0] sfr_addr,
  input logic [7:0] sfr_wdata,
  input logic [7:0] sfr_rdata,
  input logic x_req,
  input logic x_we,
  input logic [15:0] data_pointer,
  input logic x_done,
  input logic cpu_wait
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ====================
  // data port timing
  a_done_one_cycle: assert property (x_done |=> !x_done)
    else $error("done held too long");
  a_flash_read_fast: assert property (
    $rose(x_req) && !x_we && data_pointer <= 16'h3ffe |=> x_done)
    else $error("flash read slow");
  a_read_no_wait: assert property (x_req && !x_we |-> !cpu_wait)
    else $error("stall on read");
  a_ee_read_time: assert property (
    $rose(x_req) && !x_we && data_pointer[15:8] == 8'hee |=> !x_done [*8] ##[50:53] x_done)
    else $error("eeprom read time");
  a_wait_on_write: assert property (cpu_wait |-> x_req && x_we)
    else $error("stall outside write");
  a_stall_released: assert property ($rose(cpu_wait) |-> ##[1:200] !cpu_wait)
    else $error("stall not released");
  a_odd_ee_refused: assert property (
    $rose(x_req) && x_we && data_pointer[15:8] == 8'hee && data_pointer[0] |=> x_done)
    else $error("odd eeprom write accepted");
  // ====================
  // register readback
  a_whole_flag_read: assert property (
    sfr_wr && sfr_addr == 8'h97 ##1 sfr_addr == 8'h97 && !sfr_wr
    |=> sfr_rdata[0] == ($past(sfr_wdata, 2) == 8'h65))
    else $error("whole area flag");
  a_unlock_read: assert property (
    sfr_wr && sfr_addr == 8'hc9 ##1 sfr_addr == 8'hc9 && !sfr_wr
    |=> sfr_rdata[7] == ($past(sfr_wdata, 2) == 8'h47))
    else $error("flash unlock flag");
  a_ee_unlock_read: assert property (
    sfr_wr && sfr_addr == 8'hc9 ##1 sfr_addr == 8'hc9 && !sfr_wr
    |=> sfr_rdata[5] == ($past(sfr_wdata, 2) == 8'he2))
    else $error("eeprom unlock flag");
  a_aux_read: assert property (
    sfr_wr && sfr_addr == 8'hf7 ##1 sfr_addr == 8'hf7 && !sfr_wr
    |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("aux register");
endmodule : fewc_checker

// ===== bench/tb_flash_eeprom_write_control.sv
module tb_flash_eeprom_write_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic nrst;
  logic write_fail;
  logic cmd_valid;
  logic [1:0] cmd_kind;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_data;
  logic cmd_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic [1:0] wdm;
  logic wdt_run;
  logic wdt_idle;
  int n_errors;
  int checks;
  int stall;
  logic [7:0] mem [logic [15:0]];
  fewc_if fewc_if_i ();
  fewc_device #(.FLASH_WRITE_CYC(20), .EE_WRITE_CYC(30), .TO1_CYC(10), .TO2_CYC(40),
    .TO3_CYC(80)) fewc_device_i (.clk(clk), .nrst(nrst), .bus(fewc_if_i.device),
    .watchdog_reset_mode(wdm), .wdt_run_enable(wdt_run), .wdt_idle_enable(wdt_idle),
    .write_fail(write_fail));
  fewc_cpu_end fewc_cpu_end_i (.clk(clk), .nrst(nrst), .bus(fewc_if_i.cpu), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid));
  fewc_checker fewc_checker_i (.clk(clk), .nrst(nrst), .sfr_wr(fewc_if_i.sfr_wr),
    .sfr_addr(fewc_if_i.sfr_addr), .sfr_wdata(fewc_if_i.sfr_wdata),
    .sfr_rdata(fewc_if_i.sfr_rdata), .x_req(fewc_if_i.x_req), .x_we(fewc_if_i.x_we),
    .data_pointer(fewc_if_i.data_pointer), .x_done(fewc_if_i.x_done), .cpu_wait(fewc_if_i.cpu_wait));
  // ====================
  // helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte
  task automatic chk_range(input string what, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, g);
    end
  endtask : chk_range
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic do_cmd(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    stall = 0;
    cmd_kind = k;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    tick();
    cmd_valid = 1'b0;
    while (((k == 2'b01 || k == 2'b10) ? rsp_valid : cmd_ready) !== 1'b1 && n < 400) begin
      tick();
      n++;
      stall += int'(fewc_if_i.cpu_wait === 1'b1);
    end
    if (n >= 400) begin
      n_errors++;
      $display("mismatch handshake expected answer seen none");
      report_and_stop();
    end
  endtask : do_cmd
  task automatic sfr(input logic [7:0] a, input logic [7:0] d);
    do_cmd(2'b00, {8'h00, a}, d);
    repeat (3) tick();
  endtask : sfr
  function automatic bit ok_wr(input logic [15:0] a, input logic [7:0] ul, input bit wh);
    return (a <= 16'h3ffe && ul == 8'h47 && (wh || (a >= 16'h3f00 && a <= 16'h3ff7)))
      || (a[15:8] == 8'hee && !a[0] && ul == 8'he2);
  endfunction : ok_wr
  // ====================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    logic [15:0] a;
    logic [15:0] ra;
    logic [7:0] ul;
    logic [7:0] d;
    bit wh;
    bit ok;
    int lo;
    nrst = 1'b0;
    write_fail = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = 2'b00;
    cmd_addr = 16'h0000;
    cmd_data = 8'h00;
    n_errors = 0;
    checks = 0;
    void'($urandom(16044));
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    chk_byte("wdt mode", 8'h00, {6'h00, wdm});
    for (int m = 0; m < 4; m++) begin
      sfr(8'hf7, {m[1:0], 6'h06});
      chk_byte("wdt mode", {6'h00, m[1:0]}, {6'h00, wdm});
      chk_byte("wdt enables", {6'h00, m[1:0] == 2'b11, m[1]}, {6'h00, wdt_idle, wdt_run});
    end
    sfr(8'hf7, 8'h06);
    $display("test watchdog done");
    for (int i = 0; i < 40; i++) begin
      case ($urandom_range(3))
        0: a = 16'h3f00 + 16'($urandom_range(247));
        1: a = 16'($urandom_range(16'h3eff));
        2: a = 16'h3ff8 + 16'($urandom_range(6));
        default: a = 16'hee00 + 16'($urandom_range(255));
      endcase
      if (i == 0) a = 16'h3ffe;
      if (i == 1) a = 16'heefe;
      ra = (a[15:8] == 8'hee) ? {a[15:1], 1'b0} : a;
      d = 8'($urandom);
      sfr(8'h97, 8'h65);
      sfr(8'hc9, (a[15:8] == 8'hee) ? 8'he2 : 8'h47);
      do_cmd(2'b01, ra, d);
      mem[ra] = d;
      wh = 1'($urandom_range(1));
      ul = ($urandom_range(2) == 0) ? 8'h47 : ($urandom_range(1) == 0) ? 8'he2 : 8'($urandom);
      sfr(8'h97, wh ? 8'h65 : 8'h00);
      sfr(8'hc9, ul);
      ok = ok_wr(a, ul, wh);
      d = 8'($urandom);
      do_cmd(2'b01, a, d);
      lo = ok ? ((a[15:8] == 8'hee) ? 30 : 20) : 0;
      chk_range("write stall", ok ? lo - 3 : 0, ok ? lo + 3 : 1, stall);
      if (ok) mem[a] = d;
      sfr(8'hc9, 8'h00);
      if (a <= 16'h3ffe) begin
        do_cmd(2'b11, a, 8'h00);
        tick();
        chk_byte("code read", mem[a], fewc_if_i.x_rdata);
      end
      do_cmd(2'b10, ra, 8'h00);
      chk_byte("data read", mem[ra], rsp_data);
    end
    sfr(8'h97, 8'h00);
    $display("test random writes done");
    write_fail = 1'b1;
    for (int s = 1; s < 5; s++) begin
      ra = (s == 4) ? 16'hee04 : 16'h3f10;
      sfr(8'hf7, {5'h00, (s == 4) ? 2'b01 : s[1:0], 1'b0});
      sfr(8'hc9, (s == 4) ? 8'he2 : 8'h47);
      do_cmd(2'b01, ra, 8'h3c);
      lo = (s == 2) ? 40 : (s == 3) ? 80 : 10;
      chk_range("timeout stall", lo - 3, lo + 3, stall);
      // code read at c9h points the register read port at the unlock register
      do_cmd(2'b11, 16'h00c9, 8'h00);
      tick();
      chk_byte("timeout flag", 8'h01, {7'h00, fewc_if_i.sfr_rdata[6]});
      sfr(8'hc9, 8'h00);
      do_cmd(2'b11, 16'h00c9, 8'h00);
      tick();
      chk_byte("timeout clear", 8'h00, {7'h00, fewc_if_i.sfr_rdata[6]});
    end
    write_fail = 1'b0;
    sfr(8'hf7, 8'h06);
    $display("test timeout done");
    report_and_stop();
  end
endmodule : tb_flash_eeprom_write_control
